/* src/osb_bank.sv */
// Paged setpoint register bank with target formation
`timescale 1ns/1ps
`default_nettype none
module osb_bank
	import osb_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic srst, // Sync reset
	input wire osb_pkg::osb_cmd_t cmd, // Decoded command
	input wire osb_pkg::osb_src_t [osb_pkg::NPAGE-1:0] src_sel, // Run-control source
	input wire logic [osb_pkg::NPAGE-1:0][15:0] nominal_setpoint, // Nominal mV
	output logic [15:0] rd_data_r, // Read word
	output logic rd_valid_r, // Read word valid
	output logic cmd_err_r, // Unsupported command
	output logic [osb_pkg::NPAGE-1:0][23:0] target_uv, // Slewed target uV
	output logic [osb_pkg::NPAGE-1:0][15:0] droop_gain_r // Active droop gain
);
	logic [15:0] trim_r [NPAGE];
	logic [15:0] upper_r [NPAGE];
	logic [15:0] high_r [NPAGE];
	logic [15:0] low_r [NPAGE];
	logic [15:0] rate_r [NPAGE];
	logic [15:0] droop_r [NPAGE];
	logic [15:0] lower_r [NPAGE];
	logic [15:0] rate_act_r [NPAGE];
	logic known;
	logic commit;
	logic [15:0] rd_mux;
	logic rd_bad;
	logic wr_bad;

	// Command decode
	assign known = cmd.code inside {CMD_TRIM, CMD_UPPER, CMD_HIGH, CMD_LOW,
		CMD_RATE, CMD_DROOP, CMD_LOWER};
	assign commit = cmd.wr && cmd.code == CMD_COMMIT;

	genvar p;
	generate
		for (p = 0; p < NPAGE; p++)
		begin : g_page
			logic wsel;
			logic signed [17:0] trim_s;
			logic signed [17:0] base_s;
			logic signed [17:0] sum_s;
			logic [15:0] cap;
			logic [15:0] sum_mv;
			logic [15:0] goal_mv;
			logic [15:0] step;
			logic [31:0] step_w;
			logic [25:0] goal_w;
			assign wsel = cmd.wr && cmd.page == 1'(p);

			// Trim offset, stored verbatim
			always_ff @(posedge clk)
			begin
				if (srst)
					trim_r[p] <= RST_TRIM;
				else if (wsel && cmd.code == CMD_TRIM)
					trim_r[p] <= cmd.data;
			end

			// Upper clamp
			always_ff @(posedge clk)
			begin
				if (srst)
					upper_r[p] <= RST_UPPER;
				else if (wsel && cmd.code == CMD_UPPER)
					upper_r[p] <= cmd.data;
			end

			// Margin-high setpoint
			always_ff @(posedge clk)
			begin
				if (srst)
					high_r[p] <= RST_HIGH;
				else if (wsel && cmd.code == CMD_HIGH)
					high_r[p] <= cmd.data;
			end

			// Margin-low setpoint
			always_ff @(posedge clk)
			begin
				if (srst)
					low_r[p] <= RST_LOW;
				else if (wsel && cmd.code == CMD_LOW)
					low_r[p] <= cmd.data;
			end

			// Pending slew rate, idle until commit
			always_ff @(posedge clk)
			begin
				if (srst)
					rate_r[p] <= RST_RATE;
				else if (wsel && cmd.code == CMD_RATE)
					rate_r[p] <= cmd.data;
			end

			// Pending droop gain, idle until commit
			always_ff @(posedge clk)
			begin
				if (srst)
					droop_r[p] <= RST_DROOP;
				else if (wsel && cmd.code == CMD_DROOP)
					droop_r[p] <= cmd.data;
			end

			// Lower clamp
			always_ff @(posedge clk)
			begin
				if (srst)
					lower_r[p] <= RST_LOWER;
				else if (wsel && cmd.code == CMD_LOWER)
					lower_r[p] <= cmd.data;
			end

			// Active slew rate, held to its usable range at commit
			always_ff @(posedge clk)
			begin
				if (srst)
					rate_act_r[p] <= RST_RATE;
				else if (commit)
					rate_act_r[p] <= (rate_r[p] < RATE_MIN) ? RATE_MIN :
						(rate_r[p] > RATE_MAX) ? RATE_MAX : rate_r[p];
			end

			// Active droop gain, limited at commit
			always_ff @(posedge clk)
			begin
				if (srst)
					droop_gain_r[p] <= RST_DROOP;
				else if (commit)
					droop_gain_r[p] <= (droop_r[p] > DROOP_MAX) ? DROOP_MAX : droop_r[p];
			end

			// Source select, code 11 falls back to nominal
			always_comb
			begin
				unique case (src_sel[p])
					SRC_LOW: base_s = {2'b00, low_r[p]};
					SRC_HIGH: base_s = {2'b00, high_r[p]};
					SRC_NOM, SRC_NONE: base_s = {2'b00, nominal_setpoint[p]};
				endcase
			end

			// Trim saturated to its range, then added
			assign trim_s = ($signed(trim_r[p]) > TRIM_LIM_MV) ? TRIM_LIM_MV :
				($signed(trim_r[p]) < -TRIM_LIM_MV) ? -TRIM_LIM_MV : 18'($signed(trim_r[p]));
			assign sum_s = base_s + trim_s;
			assign sum_mv = sum_s[17] ? 16'h0000 : (sum_s[16] ? 16'hFFFF : sum_s[15:0]);
			assign cap = (upper_r[p] > UPPER_LIM_MV) ? UPPER_LIM_MV : upper_r[p];

			// Raise to lower clamp first so the upper clamp always wins
			always_comb
			begin
				goal_mv = (sum_mv < lower_r[p]) ? lower_r[p] : sum_mv;
				if (goal_mv > cap)
					goal_mv = cap;
			end

			// Millivolts to microvolts, rate to microvolts per cycle
			assign goal_w = goal_mv * UV_PER_MV;
			assign step_w = 32'(rate_act_r[p]) * SLEW_UV_PER_LSB / CLK_MHZ;
			assign step = step_w[15:0];

			osb_slew u_slew (
				.clk(clk),
				.srst(srst),
				.goal_uv(goal_w[23:0]),
				.step_uv(step),
				.cur_uv_r(target_uv[p])
			);
		end
	endgenerate

	// Read mux for the addressed page
	always_comb
	begin
		unique case (cmd.code)
			CMD_TRIM: rd_mux = trim_r[cmd.page];
			CMD_UPPER: rd_mux = upper_r[cmd.page];
			CMD_HIGH: rd_mux = high_r[cmd.page];
			CMD_LOW: rd_mux = low_r[cmd.page];
			CMD_RATE: rd_mux = rate_r[cmd.page];
			CMD_DROOP: rd_mux = droop_r[cmd.page];
			CMD_LOWER: rd_mux = lower_r[cmd.page];
			default: rd_mux = 16'h0000;
		endcase
	end

	// Read valid pulse one cycle after request
	always_ff @(posedge clk)
	begin
		if (srst)
			rd_valid_r <= 1'b0;
		else
			rd_valid_r <= cmd.rd && known;
	end

	// Read word, zero while no answer stands
	always_ff @(posedge clk)
	begin
		if (srst)
			rd_data_r <= 16'h0000;
		else
			rd_data_r <= (cmd.rd && known) ? rd_mux : 16'h0000;
	end

	// Error causes: unknown code, or a read of the write-only commit
	assign rd_bad = cmd.rd && !known;
	assign wr_bad = cmd.wr && !known && !commit;

	// Error pulse for unsupported codes or commit read
	always_ff @(posedge clk)
	begin
		if (srst)
			cmd_err_r <= 1'b0;
		else
			cmd_err_r <= rd_bad || wr_bad;
	end
endmodule
`default_nettype wire

/* src/osb_pkg.sv */
// Constants and types of the output setpoint register bank
package osb_pkg;
	localparam int NPAGE = 2;
	// Command codes
	localparam logic [7:0] CMD_TRIM = 8'h22;
	localparam logic [7:0] CMD_UPPER = 8'h24;
	localparam logic [7:0] CMD_HIGH = 8'h25;
	localparam logic [7:0] CMD_LOW = 8'h26;
	localparam logic [7:0] CMD_RATE = 8'h27;
	localparam logic [7:0] CMD_DROOP = 8'h28;
	localparam logic [7:0] CMD_LOWER = 8'h2B;
	localparam logic [7:0] CMD_COMMIT = 8'hE7;
	// Reset values
	localparam logic [15:0] RST_TRIM = 16'h0000;
	localparam logic [15:0] RST_UPPER = 16'h08FC;
	localparam logic [15:0] RST_HIGH = 16'h0640;
	localparam logic [15:0] RST_LOW = 16'h00FA;
	localparam logic [15:0] RST_RATE = 16'h0064;
	localparam logic [15:0] RST_DROOP = 16'h0000;
	localparam logic [15:0] RST_LOWER = 16'h0000;
	localparam logic [23:0] RST_TARGET = 24'h00_0000;
	// Limits
	localparam logic signed [17:0] TRIM_LIM_MV = 18'sh0_00FA;
	localparam logic [15:0] UPPER_LIM_MV = 16'h0CE4;
	localparam logic [15:0] RATE_MIN = 16'h0001;
	localparam logic [15:0] RATE_MAX = 16'h03E8;
	localparam logic [15:0] DROOP_MAX = 16'h0640;
	// Scaling: rate lsb 100 uV/us, clock 100 MHz, 1000 uV per mV
	localparam int SLEW_UV_PER_LSB = 100;
	localparam int CLK_MHZ = 100;
	localparam logic [9:0] UV_PER_MV = 10'h3E8;
	// Setpoint source field codes
	typedef enum logic [1:0] {
		SRC_NOM = 2'b00,
		SRC_LOW = 2'b01,
		SRC_HIGH = 2'b10,
		SRC_NONE = 2'b11
	} osb_src_t;
	// One command from the bus decoder
	typedef struct packed {
		logic wr;
		logic rd;
		logic page;
		logic [7:0] code;
		logic [15:0] data;
	} osb_cmd_t;
endpackage

/* src/osb_slew.sv */
// Target ramp that moves a microvolt value toward its goal
`timescale 1ns/1ps
`default_nettype none
module osb_slew
	import osb_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic srst, // Sync reset
	input wire logic [23:0] goal_uv, // Clamped goal
	input wire logic [15:0] step_uv, // Step per cycle
	output logic [23:0] cur_uv_r // Slewed target
);
	logic [24:0] up_sum;
	logic [24:0] dn_dif;
	assign up_sum = {1'b0, cur_uv_r} + {9'h0, step_uv};
	assign dn_dif = {1'b0, cur_uv_r} - {9'h0, step_uv};
	// Step toward goal, never overshoot
	always_ff @(posedge clk)
	begin
		if (srst)
			cur_uv_r <= RST_TARGET;
		else if (cur_uv_r < goal_uv)
			cur_uv_r <= (up_sum >= {1'b0, goal_uv}) ? goal_uv : up_sum[23:0];
		else if (cur_uv_r > goal_uv)
			cur_uv_r <= (dn_dif[24] || dn_dif <= {1'b0, goal_uv}) ? goal_uv : dn_dif[23:0];
	end
endmodule
`default_nettype wire

/* tb/osb_host.sv */
// Host model issuing bank commands
`timescale 1ns/1ps
`default_nettype none
module osb_host
	import osb_pkg::*;
(
	input wire logic clk, // Core clock
	output var osb_pkg::osb_cmd_t cmd // Command to bank
);
	initial cmd = '0;
	// One command held over exactly one taking edge
	task automatic send(input logic w, input logic p, input logic [7:0] c, input logic [15:0] d);
		@(posedge clk);
		#1 cmd = {w, !w, p, c, d};
		@(posedge clk);
		#1 cmd = '0;
	endtask
endmodule
`default_nettype wire

/* tb/osb_bank_checker.sv */
// Port assertions for the setpoint bank
`timescale 1ns/1ps
`default_nettype none
module osb_bank_checker
	import osb_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic srst, // Sync reset
	input wire osb_pkg::osb_cmd_t cmd, // Command
	input wire logic [15:0] rd_data_r, // Read word
	input wire logic rd_valid_r, // Read valid
	input wire logic cmd_err_r, // Error pulse
	input wire logic [osb_pkg::NPAGE-1:0][23:0] target_uv, // Target
	input wire logic [osb_pkg::NPAGE-1:0][15:0] droop_gain_r // Droop
);
	// One clock, reset masks all checks
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_no_stray_valid: assert property (!cmd.rd |=> !rd_valid_r)
		else $error("read valid without read");
	a_idle_data_zero: assert property (!rd_valid_r |-> rd_data_r == 16'h0000)
		else $error("read data not zero when idle");
	a_read_answer: assert property (cmd.rd && cmd.code == CMD_TRIM |=> rd_valid_r)
		else $error("read not answered");
	a_unmapped_err: assert property (cmd.rd && cmd.code == 8'h23 |=> cmd_err_r)
		else $error("unmapped read not flagged");
	a_commit_no_err: assert property (cmd.wr && cmd.code == CMD_COMMIT |=> !cmd_err_r)
		else $error("commit flagged as error");
	a_upper_cap: assert property (target_uv[0] <= 24'h32_5AA0)
		else $error("target above cap");
	a_slew_step: assert property (target_uv[0] <= $past(target_uv[0]) + 24'h00_03E8
		&& $past(target_uv[0]) <= target_uv[0] + 24'h00_03E8)
		else $error("target step too large");
	a_droop_max: assert property (droop_gain_r[0] <= 16'h0640)
		else $error("droop above limit");
	a_droop_commit: assert property (!$stable(droop_gain_r)
		|-> $past(cmd.wr) && $past(cmd.code) == CMD_COMMIT)
		else $error("droop changed without commit");
endmodule
bind osb_bank osb_bank_checker chk (.clk(clk), .srst(srst), .cmd(cmd),
	.rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .cmd_err_r(cmd_err_r),
	.target_uv(target_uv), .droop_gain_r(droop_gain_r));
`default_nettype wire

/* tb/test_osb_bank.sv */
// Self-checking bench for the setpoint bank
`timescale 1ns/1ps
`default_nettype none
module test_osb_bank;
	import osb_pkg::*;
	logic clk, srst;
	osb_cmd_t cmd;
	osb_src_t [NPAGE-1:0] src_sel;
	logic [NPAGE-1:0][15:0] nom, droop_gain_r;
	logic [15:0] rd_data_r, d;
	logic rd_valid_r, cmd_err_r;
	logic [NPAGE-1:0][23:0] target_uv;
	logic [23:0] e;
	int err_count = 0, n_tests = 0, cyc = 0, tr, lo, hi;
	int sp [3];
	logic [7:0] codes [7] = '{CMD_TRIM, CMD_UPPER, CMD_HIGH, CMD_LOW, CMD_RATE, CMD_DROOP, CMD_LOWER};
	logic [15:0] rsts [7] = '{RST_TRIM, RST_UPPER, RST_HIGH, RST_LOW, RST_RATE, RST_DROOP, RST_LOWER};
	osb_host host (.clk(clk), .cmd(cmd));
	osb_bank dut (.clk(clk), .srst(srst), .cmd(cmd), .src_sel(src_sel),
		.nominal_setpoint(nom), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
		.cmd_err_r(cmd_err_r), .target_uv(target_uv), .droop_gain_r(droop_gain_r));
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			err_count++;
			test_done;
		end
	end
	task automatic check(input string nm, input logic [23:0] x, input logic [23:0] s);
		n_tests++;
		if (s !== x)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic rd(input logic p, input int i, input logic [15:0] x);
		host.send(1'b0, p, codes[i], 16'h0000);
		check("valid", 24'h00_0001, {23'h0, rd_valid_r});
		check("read", {8'h00, x}, {8'h00, rd_data_r});
	endtask
	// Expected goal: trim saturated, floor at zero, lower then upper and cap
	function automatic logic [23:0] goal(input int s, input int t, input int l, input int h);
		s = s + (t > TRIM_LIM_MV ? TRIM_LIM_MV : t < -TRIM_LIM_MV ? -TRIM_LIM_MV : t);
		s = s < 0 ? 0 : s;
		s = s < l ? l : s;
		s = s > h ? h : s;
		s = s > UPPER_LIM_MV ? UPPER_LIM_MV : s;
		return 24'(s * 1000);
	endfunction
	task automatic test_done;
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		void'($urandom(4));
		srst = 1'b1;
		src_sel = '0;
		nom = {16'($urandom % 3301), 16'h0BB8};
		repeat (6) @(posedge clk);
		#1 srst = 1'b0;
		#1000 check("slew", 24'h00_2710, target_uv[0]);
		for (int i = 0; i < 7; i++)
		begin
			d = 16'($urandom);
			host.send(1'b1, 1'b0, codes[i], d);
			rd(1'b0, i, d);
			rd(1'b1, i, rsts[i]);
		end
		srst = 1'b1;
		repeat (2) @(posedge clk);
		#1 srst = 1'b0;
		host.send(1'b0, 1'b0, 8'h23, 16'h0000);
		check("error", 24'h00_0001, {23'h0, cmd_err_r});
		host.send(1'b1, 1'b1, CMD_DROOP, 16'h07D0);
		host.send(1'b1, 1'b0, CMD_RATE, 16'h03E8);
		host.send(1'b1, 1'b1, CMD_RATE, 16'h03E8);
		check("droop", 24'h00_0000, {8'h00, droop_gain_r[1]});
		host.send(1'b1, 1'b0, CMD_COMMIT, 16'h0000);
		check("droop", {8'h00, DROOP_MAX}, {8'h00, droop_gain_r[1]});
		for (int s = 0; s < 4; s++)
		begin
			tr = int'($urandom % 601) - 300;
			lo = $urandom % 1200;
			hi = 1000 + $urandom % 2600;
			for (int k = 0; k < 3; k++) sp[k] = $urandom % 3301;
			nom[0] = 16'(sp[0]);
			src_sel[0] = osb_src_t'(s);
			host.send(1'b1, 1'b0, CMD_TRIM, 16'(tr));
			host.send(1'b1, 1'b0, CMD_LOW, 16'(sp[1]));
			host.send(1'b1, 1'b0, CMD_HIGH, 16'(sp[2]));
			host.send(1'b1, 1'b0, CMD_LOWER, 16'(lo));
			host.send(1'b1, 1'b0, CMD_UPPER, 16'(hi));
			e = goal(sp[s == 3 ? 0 : s], tr, lo, hi);
			for (int t = 0; t < 4000 && target_uv[0] !== e; t++) #10;
			check("target", e, target_uv[0]);
		end
		e = goal(nom[1], 0, 0, RST_UPPER);
		for (int t = 0; t < 4000 && target_uv[1] !== e; t++) #10;
		check("target1", e, target_uv[1]);
		test_done;
	end
endmodule
`default_nettype wire
